// [src/srsa_defines.svh]
// srsa_defines.svh: register offsets, field positions, reset values and codes
// assumes: included by bare name from src/ files of the serial register access block
`ifndef SRSA_DEFINES_SVH
`define SRSA_DEFINES_SVH

// register map (7-bit address: upper region in [6:4], lower in [3:0])
`define SRSA_ADDR_W          7
`define SRSA_URA_W           3
`define SRSA_LRA_W           4
`define SRSA_REG_COUNT       128
`define SRSA_OFS_STREAM_CTRL 7'h03
`define SRSA_OFS_RESULT_HI   7'h1a
`define SRSA_OFS_RESULT_LO   7'h1b

// stream_control fields
`define SRSA_STRM_KIND_BIT   7
`define SRSA_STRM_SPAN_MSB   2
`define SRSA_STRM_SPAN_LSB   0
`define SRSA_RST_STREAM_CTRL 8'h00
`define SRSA_RST_REG         8'h00
`define SRSA_RST_URA         3'h0

// instruction byte
`define SRSA_INSTR_URA_SETUP 8'h10
`define SRSA_INSTR_RD_BIT    7

// conversion result
`define SRSA_RAW_W           24
`define SRSA_RESULT_MAX      16'h7fff
`define SRSA_RESULT_MIN      16'h8000
`define SRSA_RESULT_RST      16'h0000

`endif

// [src/srsa_pkg.sv]
// srsa_pkg: types shared by the serial register access block
// assumes: constants come from srsa_defines.svh
`default_nettype none
`include "srsa_defines.svh"

package srsa_pkg;

  // frame phase of the serial port
  typedef enum logic [1:0] {
    SRSA_PH_INSTR = 2'b00,
    SRSA_PH_URA   = 2'b01,
    SRSA_PH_WRITE = 2'b10,
    SRSA_PH_READ  = 2'b11
  } srsa_phase_t;

  // one prefetched read byte with its source address
  typedef struct packed {
    logic [`SRSA_ADDR_W-1:0] addr;
    logic [7:0]              data;
  } srsa_rd_item_t;

endpackage

`default_nettype wire

// [src/srsa_buf.sv]
// srsa_buf: two-entry valid/ready buffer for prefetched read bytes
// assumes: single clock, synchronous flush clears both entries
`timescale 1ns/1ns
`default_nettype none

module srsa_buf (
  input  wire logic                   clk,       // system clock
  input  wire logic                   rst_n,     // synchronised reset, active low
  input  wire logic                   flush,     // drop all entries
  input  wire logic                   in_valid,  // producer offers an item
  output var  logic                   in_ready,  // room for one more item
  input  wire srsa_pkg::srsa_rd_item_t in_item,  // item offered
  output var  logic                   out_valid, // head item present
  input  wire logic                   out_ready, // consumer takes head
  output var  srsa_pkg::srsa_rd_item_t out_item  // head item
);

  srsa_pkg::srsa_rd_item_t ent_q [2];
  srsa_pkg::srsa_rd_item_t ent_d [2];
  logic [1:0]              cnt_q;
  logic [1:0]              cnt_d;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_item  = ent_q[0];

  // pop shifts entry 1 down; push lands behind the survivors
  always_comb begin
    logic do_push;
    logic do_pop;
    do_push  = in_valid && in_ready;
    do_pop   = out_valid && out_ready;
    ent_d[0] = ent_q[0];
    ent_d[1] = ent_q[1];
    cnt_d    = cnt_q;
    if (do_pop) begin
      ent_d[0] = ent_q[1];
    end
    if (do_push) begin
      if (cnt_q == 2'h0 || (cnt_q == 2'h1 && do_pop)) begin
        ent_d[0] = in_item;
      end else begin
        ent_d[1] = in_item;
      end
    end
    cnt_d = cnt_q + {1'b0, do_push} - {1'b0, do_pop};
    if (flush) begin
      cnt_d = 2'h0;
    end
  end

  // storage registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ent_q[0] <= '0;
      ent_q[1] <= '0;
      cnt_q    <= 2'h0;
    end else begin
      ent_q[0] <= ent_d[0];
      ent_q[1] <= ent_d[1];
      cnt_q    <= cnt_d;
    end
  end

endmodule

`default_nettype wire

// [src/srsa_top.sv]
// srsa_top: serial register access front end with streaming and result clamping
// assumes: master uses mode 0 (sample on rising sclk, device shifts on falling),
// sclk slow enough for sys_clk to see every level (8 samples per period or more)
//
// Contract
// - the conversion result is a 16-bit two's complement value split into a high and a low byte.
// - the largest reportable result is 0x7fff and the smallest is 0x8000.
// - an over-range input saturates at the nearer extreme code rather than wrapping.
// - a multi-byte write stores each byte at the next incremented address.
// - the upper address persists across frames so the master may skip its setup frame.
// - a multi-byte read returns bytes from incrementing addresses.
// - after reset the stream kind is normal, where a burst keeps incrementing.
// - setting the stream kind bit at 0x03 selects controlled streaming.
// - the wrap span field holds the window size minus one.
// - in controlled streaming the address returns to the start after the window's last register.
// - the result high byte sits at 0x1a and the low byte at 0x1b.
`timescale 1ns/1ns
`default_nettype none
`include "srsa_defines.svh"

module srsa_top (
  input  wire logic                          sys_clk,      // 20 MHz system clock
  input  wire logic                          rst_n,        // async reset, active low
  input  wire logic                          sclk,         // serial clock from master
  input  wire logic                          select_low_n, // frame select, active low
  input  wire logic                          sdi,          // serial data in
  output var  logic                          sdo,          // serial data out
  output var  logic                          sdo_oe_n,     // sdo enable, low drives
  input  wire logic signed [`SRSA_RAW_W-1:0] conv_raw,     // raw converter value
  input  wire logic                          conv_valid    // raw value strobe
);

  // reset release through two flops
  logic rst_s1_q;
  logic rst_sync_n;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_q   <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  // pin synchronisers; only stage two and later are read by logic
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic sel_s1_q, sel_s2_q;
  logic sdi_s1_q, sdi_s2_q;
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      sel_s1_q  <= 1'b1;
      sel_s2_q  <= 1'b1;
      sdi_s1_q  <= 1'b0;
      sdi_s2_q  <= 1'b0;
    end else begin
      sclk_s1_q <= sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sel_s1_q  <= select_low_n;
      sel_s2_q  <= sel_s1_q;
      sdi_s1_q  <= sdi;
      sdi_s2_q  <= sdi_s1_q;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sclk_s2_q && !sclk_s3_q;
  assign sclk_fall = !sclk_s2_q && sclk_s3_q;

  // port state
  srsa_pkg::srsa_phase_t   phase_q, phase_d;
  logic [2:0]              bit_cnt_q, bit_cnt_d;
  logic [7:0]              sh_in_q, sh_in_d;
  logic [7:0]              sh_out_q, sh_out_d;
  logic                    sdo_q, sdo_d;
  logic                    sdo_oe_n_q, sdo_oe_n_d;
  logic [`SRSA_URA_W-1:0]  ura_q, ura_d;
  logic [`SRSA_ADDR_W-1:0] addr_q, addr_d;
  logic [`SRSA_ADDR_W-1:0] base_q, base_d;
  logic [15:0]             result_q, result_d;
  logic [7:0]              mem_q [`SRSA_REG_COUNT];
  logic [7:0]              mem_d [`SRSA_REG_COUNT];

  // buffer hookup
  logic                    buf_push, buf_in_ready, buf_out_valid, buf_pop, buf_flush;
  srsa_pkg::srsa_rd_item_t buf_in_item, buf_out_item;

  srsa_buf u_rd_buf (
    .clk       (sys_clk),
    .rst_n     (rst_sync_n),
    .flush     (buf_flush),
    .in_valid  (buf_push),
    .in_ready  (buf_in_ready),
    .in_item   (buf_in_item),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_item  (buf_out_item)
  );

  // stream control fields straight from the register array
  logic                 strm_kind;
  logic [2:0]           strm_span;
  assign strm_kind = mem_q[`SRSA_OFS_STREAM_CTRL][`SRSA_STRM_KIND_BIT];
  assign strm_span = mem_q[`SRSA_OFS_STREAM_CTRL][`SRSA_STRM_SPAN_MSB:`SRSA_STRM_SPAN_LSB];

  // burst address step: wrap at base+span in controlled mode, else increment
  function automatic logic [`SRSA_ADDR_W-1:0] step_addr(
    input logic [`SRSA_ADDR_W-1:0] a,
    input logic [`SRSA_ADDR_W-1:0] base,
    input logic                    kind,
    input logic [2:0]              span
  );
    logic [`SRSA_ADDR_W-1:0] last;
    last = base + {4'h0, span};
    if (kind && a == last) begin
      step_addr = base;
    end else begin
      step_addr = a + 7'h01;
    end
  endfunction

  // read view: result bytes replace the plain storage at their offsets
  function automatic logic [7:0] read_byte(
    input logic [`SRSA_ADDR_W-1:0] a,
    input logic [7:0]              stored,
    input logic [15:0]             res
  );
    if (a == `SRSA_OFS_RESULT_HI) begin
      read_byte = res[15:8];
    end else if (a == `SRSA_OFS_RESULT_LO) begin
      read_byte = res[7:0];
    end else begin
      read_byte = stored;
    end
  endfunction

  assign buf_in_item.addr = addr_q;
  assign buf_in_item.data = read_byte(addr_q, mem_q[addr_q], result_q);

  // clamp the raw value into the 16-bit code range
  always_comb begin
    result_d = result_q;
    if (conv_valid) begin
      if (conv_raw > $signed(24'sh007fff)) begin
        result_d = `SRSA_RESULT_MAX;
      end else if (conv_raw < $signed(24'shff8000)) begin
        result_d = `SRSA_RESULT_MIN;
      end else begin
        result_d = conv_raw[15:0];
      end
    end
  end

  // serial port next state
  always_comb begin
    logic [7:0] rx_byte;
    rx_byte    = {sh_in_q[6:0], sdi_s2_q};
    phase_d    = phase_q;
    bit_cnt_d  = bit_cnt_q;
    sh_in_d    = sh_in_q;
    sh_out_d   = sh_out_q;
    sdo_d      = sdo_q;
    sdo_oe_n_d = sdo_oe_n_q;
    ura_d      = ura_q;
    addr_d     = addr_q;
    base_d     = base_q;
    buf_push   = 1'b0;
    buf_pop    = 1'b0;
    buf_flush  = 1'b0;
    for (int i = 0; i < `SRSA_REG_COUNT; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (sel_s2_q) begin
      // frame over: drop prefetch, release sdo; ura_q survives
      phase_d    = srsa_pkg::SRSA_PH_INSTR;
      bit_cnt_d  = 3'h0;
      sdo_oe_n_d = 1'b1;
      buf_flush  = 1'b1;
    end else begin
      sdo_oe_n_d = (phase_q != srsa_pkg::SRSA_PH_READ);
      if (sclk_rise) begin
        sh_in_d   = rx_byte;
        bit_cnt_d = bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7) begin
          unique case (phase_q)
            srsa_pkg::SRSA_PH_INSTR: begin
              if (rx_byte == `SRSA_INSTR_URA_SETUP) begin
                phase_d = srsa_pkg::SRSA_PH_URA;
              end else begin
                addr_d  = {ura_q, rx_byte[`SRSA_LRA_W-1:0]};
                base_d  = {ura_q, rx_byte[`SRSA_LRA_W-1:0]};
                phase_d = rx_byte[`SRSA_INSTR_RD_BIT] ? srsa_pkg::SRSA_PH_READ
                                                      : srsa_pkg::SRSA_PH_WRITE;
              end
            end
            srsa_pkg::SRSA_PH_URA: begin
              ura_d   = rx_byte[`SRSA_URA_W-1:0];
              phase_d = srsa_pkg::SRSA_PH_INSTR;
            end
            srsa_pkg::SRSA_PH_WRITE: begin
              // result bytes are read-only; writes there are dropped
              if (addr_q != `SRSA_OFS_RESULT_HI && addr_q != `SRSA_OFS_RESULT_LO) begin
                mem_d[addr_q] = rx_byte;
              end
              addr_d = step_addr(addr_q, base_q, strm_kind, strm_span);
            end
            srsa_pkg::SRSA_PH_READ: begin
              bit_cnt_d = 3'h0;
            end
          endcase
        end
      end
      if (phase_q == srsa_pkg::SRSA_PH_READ) begin
        // prefetch runs ahead by two bytes so a byte is ready at each boundary
        if (buf_in_ready) begin
          buf_push = 1'b1;
          addr_d   = step_addr(addr_q, base_q, strm_kind, strm_span);
        end
        if (sclk_fall) begin
          if (bit_cnt_q == 3'h0 && buf_out_valid) begin
            buf_pop  = 1'b1;
            sdo_d    = buf_out_item.data[7];
            sh_out_d = {buf_out_item.data[6:0], 1'b0};
          end else begin
            sdo_d    = sh_out_q[7];
            sh_out_d = {sh_out_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  // port registers
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase_q    <= srsa_pkg::SRSA_PH_INSTR;
      bit_cnt_q  <= 3'h0;
      sh_in_q    <= 8'h00;
      sh_out_q   <= 8'h00;
      sdo_q      <= 1'b0;
      sdo_oe_n_q <= 1'b1;
      ura_q      <= `SRSA_RST_URA;
      addr_q     <= 7'h00;
      base_q     <= 7'h00;
      result_q   <= `SRSA_RESULT_RST;
    end else begin
      phase_q    <= phase_d;
      bit_cnt_q  <= bit_cnt_d;
      sh_in_q    <= sh_in_d;
      sh_out_q   <= sh_out_d;
      sdo_q      <= sdo_d;
      sdo_oe_n_q <= sdo_oe_n_d;
      ura_q      <= ura_d;
      addr_q     <= addr_d;
      base_q     <= base_d;
      result_q   <= result_d;
    end
  end

  // register array, one flop byte per address; stream control resets to normal
  for (genvar g = 0; g < `SRSA_REG_COUNT; g++) begin : g_reg
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        mem_q[g] <= (g == `SRSA_OFS_STREAM_CTRL) ? `SRSA_RST_STREAM_CTRL : `SRSA_RST_REG;
      end else begin
        mem_q[g] <= mem_d[g];
      end
    end
  end

  assign sdo      = sdo_q;
  assign sdo_oe_n = sdo_oe_n_q;

endmodule

`default_nettype wire

// [test/srsa_top_sva.sv]
// srsa_top_sva: port-level checks of the serial access front end
// assumes: bound to srsa_top, one clock domain, mode 0 link
`timescale 1ns/1ns
`default_nettype none
`include "srsa_defines.svh"

module srsa_top_sva (
  input wire logic                          sys_clk,      // clock
  input wire logic                          rst_n,        // reset, active low
  input wire logic                          sclk,         // link clock
  input wire logic                          select_low_n, // frame select
  input wire logic                          sdi,          // link data in
  input wire logic                          sdo,          // link data out
  input wire logic                          sdo_oe_n,     // out enable, low drives
  input wire logic signed [`SRSA_RAW_W-1:0] conv_raw,     // raw value
  input wire logic                          conv_valid    // raw strobe
);
  logic [2:0] sck_q;  // link clock history
  logic [2:0] sel_q;  // select history
  logic [1:0] dat_q;  // data history, aligned with sck_q
  logic [5:0] bits_q; // rising edges in frame, saturating
  logic       first_q; // first bit of frame: read flag
  logic [3:0] age_q;  // cycles since link clock fell
  logic [3:0] hi_q;   // cycles of raw select high
  wire        rise_w = sck_q[1] & ~sck_q[2];
  wire        fall_w = ~sck_q[1] & sck_q[2];

  // mirror of the frame decode, own sync so a slip in the design shows
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 3'h0;
      sel_q <= 3'h7;
      dat_q <= 2'h0;
      bits_q <= 6'h00;
      first_q <= 1'b0;
      age_q <= 4'hf;
      hi_q <= 4'hf;
    end else begin
      sck_q <= {sck_q[1:0], sclk};
      sel_q <= {sel_q[1:0], select_low_n};
      dat_q <= {dat_q[0], sdi};
      if (sel_q[1]) bits_q <= 6'h00;
      else if (rise_w && bits_q != 6'h3f) bits_q <= bits_q + 6'h01;
      if (rise_w && bits_q == 6'h00) first_q <= dat_q[1];
      age_q <= fall_w ? 4'h0 : ((age_q == 4'hf) ? 4'hf : age_q + 4'h1);
      hi_q <= !select_low_n ? 4'h0 : ((hi_q == 4'hf) ? 4'hf : hi_q + 4'h1);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // eighth rising edge of a read instruction seen
  sequence s_rd_instr;
    rise_w && bits_q == 6'd7 && first_q && !sel_q[1];
  endsequence
  sequence s_drive_start;
    ##[1:4] !sdo_oe_n;
  endsequence

  chk_read_drive_time: assert property (s_rd_instr |-> s_drive_start)
    else $error("read frame did not drive sdo in time");
  chk_oe_fall_cause: assert property ($fell(sdo_oe_n) |->
    (first_q && bits_q inside {[7:9]}) || bits_q inside {[23:25]})
    else $error("sdo drive began outside a read instruction");
  chk_write_no_drive: assert property (!sel_q[1] && !first_q && bits_q inside {[2:15]} |-> sdo_oe_n)
    else $error("sdo driven during a write frame");
  chk_oe_sel_bound: assert property (!sdo_oe_n |-> hi_q <= 4'h5)
    else $error("sdo still driven long after select rose");
  chk_oe_rise_cause: assert property ($rose(sdo_oe_n) |-> hi_q inside {[1:5]})
    else $error("sdo released while select low");
  chk_oe_stays_low: assert property (!sdo_oe_n && !select_low_n |=> !sdo_oe_n)
    else $error("sdo released inside a read frame");
  chk_sdo_edge_hold: assert property (!sdo_oe_n && !$past(sdo_oe_n) && $changed(sdo) |-> age_q <= 4'h4)
    else $error("sdo changed away from a falling link edge");
  chk_reset_idle: assert property ($rose(rst_n) |-> sdo_oe_n && !sdo)
    else $error("sdo not idle after reset");
endmodule

bind srsa_top srsa_top_sva chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .select_low_n(select_low_n),
  .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .conv_raw(conv_raw), .conv_valid(conv_valid));
`default_nettype wire

// [test/srsa_master_model.sv]
// srsa_master_model: mode 0 link master driven through tasks
// assumes: the bench calls sel and xfer, one caller at a time
`timescale 1ns/1ns
`default_nettype none

module srsa_master_model (
  output var  logic sclk,         // link clock, rests low
  output var  logic select_low_n, // frame select, active low
  output var  logic sdi,          // data to device
  input  wire logic sdo,          // device data
  input  wire logic sdo_oe_n      // device enable, low drives
);
  localparam int HALF_NS = 200;   // 400 ns link period
  int   pause_ns = 0;             // gap between bytes, a slow master
  logic hold_q = 1'b0;
  logic line;

  initial begin
    sclk = 1'b0;
    select_low_n = 1'b1;
    sdi = 1'b0;
  end
  // released line shows the inverse of its last level, never a stale copy
  always @(sdo or sdo_oe_n) if (!sdo_oe_n) hold_q = sdo;
  assign line = sdo_oe_n ? ~hold_q : sdo;

  // select moves only while the clock rests, so frames end cleanly
  task automatic sel(input logic lvl);
    #(HALF_NS);
    select_low_n = lvl;
    if (lvl) sdi = ~sdi;
    #(HALF_NS);
  endtask
  // msb first; sampled at the end of the high phase where sdo is settled
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      #(HALF_NS) sclk = 1'b1;
      #(HALF_NS) rx[i] = line;
      sclk = 1'b0;
    end
    #(pause_ns);
  endtask
endmodule
`default_nettype wire

// [test/test_srsa_top.sv]
// test_srsa_top: self-checking bench of the serial access front end
// assumes: srsa_master_model owns the link, bench owns reset and converter
`timescale 1ns/1ns
`default_nettype none

module test_srsa_top;
  typedef struct {logic [6:0] addr; logic [7:0] data; logic [7:0] exp;} srsa_row_t;
  logic               sys_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic signed [23:0] conv_raw = 24'sh000000;
  logic               conv_valid = 1'b0;
  logic               sclk, select_low_n, sdi, sdo, sdo_oe_n;
  int                 err_count = 0;
  int                 tests_run = 0;
  // 0x1b is read-only, so its write is lost
  srsa_row_t rows [6] = '{'{7'h00, 8'h5a, 8'h5a}, '{7'h1b, 8'hee, 8'h00}, '{7'h2e, 8'h01, 8'h01},
                          '{7'h3f, 8'hff, 8'hff}, '{7'h40, 8'h80, 8'h80}, '{7'h7f, 8'h3c, 8'h3c}};
  logic signed [23:0] raws [6] = '{24'sh7fffff, 24'sh008000, 24'sh007fff, 24'shff7fff, 24'shff8000, 24'shffff00};
  logic [15:0]        rexp [6] = '{16'h7fff, 16'h7fff, 16'h7fff, 16'h8000, 16'h8000, 16'hff00};

  always #25 sys_clk = ~sys_clk;

  srsa_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .select_low_n(select_low_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n), .conv_raw(conv_raw), .conv_valid(conv_valid));
  srsa_master_model m_u (.sclk(sclk), .select_low_n(select_low_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic [7:0] ins, ref logic [7:0] q[$]);
    logic [7:0] r;
    m_u.sel(1'b0);
    m_u.xfer(ins, r);
    foreach (q[i]) m_u.xfer(q[i], q[i]);
    m_u.sel(1'b1);
  endtask
  // optional upper setup frame, then the access frame
  task automatic access(input logic [6:0] a, input logic rd, input logic up, ref logic [7:0] q[$]);
    logic [7:0] s[$];
    s.push_back({5'h00, a[6:4]});
    if (up) frame(8'h10, s);
    frame({rd, 3'h0, a[3:0]}, q);
  endtask
  task automatic wr(input logic [6:0] a, input logic up, input logic [7:0] d[$]);
    access(a, 1'b0, up, d);
  endtask
  task automatic rd_cmp(input logic [6:0] a, input logic up, input logic [7:0] e[$]);
    logic [7:0] q[$];
    q = e;
    access(a, 1'b1, up, q);
    foreach (e[i]) check(q[i], e[i]);
  endtask
  task automatic conv(input logic signed [23:0] v);
    @(posedge sys_clk);
    #2 conv_raw = v;
    conv_valid = 1'b1;
    @(posedge sys_clk);
    #2 conv_valid = 1'b0;
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    #2 rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    // link timing is a multiple of 50 ns, so this offset keeps every link change off the clock edge
    #2;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    rd_cmp(7'h03, 1'b1, {8'h00});
    rd_cmp(7'h1a, 1'b1, {8'h00, 8'h00});
    $display("test reset values done");
    foreach (rows[i]) begin
      wr(rows[i].addr, 1'b1, {rows[i].data});
      rd_cmp(rows[i].addr, 1'b1, {rows[i].exp});
    end
    $display("test row accesses done");
    wr(7'h1f, 1'b1, {8'ha1, 8'hb2, 8'hc3});
    rd_cmp(7'h20, 1'b1, {8'hb2, 8'hc3});
    rd_cmp(7'h1f, 1'b1, {8'ha1});
    wr(7'h12, 1'b0, {8'h69});
    rd_cmp(7'h12, 1'b0, {8'h69});
    wr(7'h24, 1'b1, {8'h24, 8'h25});
    rd_cmp(7'h24, 1'b1, {8'h24, 8'h25});
    $display("test bursts done");
    wr(7'h28, 1'b1, {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
    m_u.pause_ns = 2000; // stalls the master so the prefetch buffer fills
    rd_cmp(7'h28, 1'b1, {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
    m_u.pause_ns = 0;
    $display("test normal stream done");
    foreach (raws[i]) begin
      conv(raws[i]);
      wr(7'h1a, 1'b1, {8'h00, 8'h00});
      rd_cmp(7'h1a, 1'b1, {rexp[i][15:8], rexp[i][7:0]});
    end
    $display("test result clamp done");
    wr(7'h03, 1'b1, {8'h81});
    conv(24'sh000abc);
    rd_cmp(7'h1a, 1'b1, {8'h0a, 8'hbc, 8'h0a, 8'hbc, 8'h0a, 8'hbc, 8'h0a, 8'hbc});
    // write bursts wrap too: the third byte lands back on the start address
    wr(7'h30, 1'b1, {8'h11, 8'h22, 8'h33});
    rd_cmp(7'h30, 1'b1, {8'h33, 8'h22, 8'h33, 8'h22});
    $display("test controlled stream done");
    do_reset();
    wr(7'h07, 1'b0, {8'h77});
    rd_cmp(7'h07, 1'b1, {8'h77});
    rd_cmp(7'h03, 1'b0, {8'h00});
    $display("test second reset done");
    report_and_stop();
  end

  // watchdog well above the roughly 0.72 ms the sequence needs
  initial begin
    #3000000;
    err_count++;
    $display("Error at %0t ns: watchdog seen %h expected %h", $time, 1'b1, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
